// ===== hw/evsel_pkg.sv
// constants and types for the exception vector selector
// assumes a 32-bit core, AHB-Lite register access, one clock
package evsel_pkg;
  // ******************************
  // event codes
  // ******************************
  typedef enum logic [3:0] {
    EV_POWER_ON,
    EV_SYS_BREAK,
    EV_UNK_OPCODE,
    EV_MISALIGN,
    EV_TRAP,
    EV_EXT_IRQ,
    EV_COPRO_IRQ,
    EV_PRIV_OP,
    EV_FETCH_ACC,
    EV_LOAD_ACC,
    EV_FETCH_TLB,
    EV_LOAD_TLB,
    EV_COPRO_OFF
  } evsel_ev_t;

  // ******************************
  // vector offsets
  // ******************************
  localparam logic [31:0] OFS_POWER_ON = 32'h0000_0000;
  localparam logic [31:0] OFS_SYS_BREAK = 32'h0000_0010;
  localparam logic [31:0] OFS_UNK_OPCODE = 32'h0000_0020;
  localparam logic [31:0] OFS_MISALIGN = 32'h0000_0030;
  localparam logic [31:0] OFS_TRAP_BASE = 32'h0000_0040;
  localparam logic [31:0] OFS_EXT_IRQ = 32'h0000_0080;
  localparam logic [31:0] OFS_COPRO_IRQ = 32'h0000_0090;
  localparam logic [31:0] OFS_PRIV_OP = 32'h0000_0100;
  localparam logic [31:0] OFS_ACCESS = 32'h0000_0110;
  localparam logic [31:0] OFS_TLB = 32'h0000_0120;
  localparam logic [31:0] OFS_COPRO_OFF = 32'h0000_0160;
  localparam logic [31:0] TRAP_PC_STEP = 32'h0000_0004;

  // ******************************
  // register map and fields
  // ******************************
  localparam logic [7:0] REG_VBASE = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_INT_STAT = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam logic [7:0] REG_LAST_PC = 8'h10;
  localparam logic [31:0] VBASE_MASK = 32'h1fff_0000;
  localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
  localparam int MMU_BIT = 31;
  localparam int INT_VECTOR = 0;
  localparam int INT_LATE_WR = 1;
  localparam int INT_ACC_AREA = 2;
  localparam int INT_W = 3;
endpackage

// ===== hw/evsel.sv
// exception vector selector: entry address, status update, saved pc
// assumes event detection and priority upstream, fetch downstream,
// and an AHB-Lite master on the same clock for the registers
`timescale 1ns/100ps

// Functional notes
// RULE_01 - power-on entry always vectors to zero
// RULE_02 - vector base resets to all zeros
// RULE_03 - vector base changes only once per reset
// RULE_04 - entry range follows mmu flag and mode
// RULE_05 - top address bit follows mmu flag
// RULE_06 - power-on clears stack, user, accept bits
// RULE_07 - break irq: offset 10, clear all, next pc
// RULE_08 - unknown opcode: offset 20, keep stack select
// RULE_09 - misaligned access: offset 30 from base
// RULE_10 - traps: offsets 40..7c, saved pc plus four
// RULE_11 - external irq: offset 80, clear all, next pc
// RULE_12 - coprocessor irq: offset 90, clear, next pc
// RULE_13 - privileged op: offset 100, keep stack select
// RULE_14 - access faults share offset 110
// RULE_15 - tlb misses share offset 120
// RULE_16 - coprocessor off: offset 160, keep stack select
// RULE_17 - later base writes ignored until reset
module evsel #(
  parameter int HADDR_W = 12
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [HADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic EV_VALID,
  input wire evsel_pkg::evsel_ev_t EV_CODE,
  input wire logic [3:0] EV_TRAP_NUM,
  input wire logic [31:0] EV_PC,
  input wire logic [31:0] EV_NEXT_PC,
  input wire logic XLATE_ON,
  input wire logic STACK_SEL_IN,
  input wire logic USER_MODE_IN,
  input wire logic IRQ_ACCEPT_IN,
  output logic VEC_VALID,
  output logic [31:0] VEC_ADDR,
  output logic VEC_ACC_AREA,
  output logic STACK_SEL_OUT,
  output logic USER_MODE_OUT,
  output logic IRQ_ACCEPT_OUT,
  output logic [31:0] SAVED_PC,
  output logic SAVED_PC_VALID,
  output logic IRQ
);
  import evsel_pkg::*;

  // ******************************
  // elaboration checks
  // ******************************
  if (HADDR_W < 5)
  begin : g_bad_addr
    $error("HADDR_W too small for the register map");
  end

  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [31:0] base;
    logic locked;
    logic mmu;
    logic [INT_W-1:0] ist;
    logic [INT_W-1:0] imask;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
    logic vld;
    logic [31:0] vaddr;
    logic acc_area;
    logic ss;
    logic um;
    logic ia;
    logic [31:0] spc;
    logic spc_vld;
    logic irq;
  } evsel_st_t;

  evsel_st_t st;
  evsel_st_t next_st;

  // per-event offset, shared by the datapath and the checks
  function automatic logic [31:0] ofs_of(evsel_ev_t c, logic [3:0] tn);
    logic [31:0] o;
    o = OFS_POWER_ON;
    case (c)
      EV_SYS_BREAK: o = OFS_SYS_BREAK; // RULE_07
      EV_UNK_OPCODE: o = OFS_UNK_OPCODE; // RULE_08
      EV_MISALIGN: o = OFS_MISALIGN; // RULE_09
      EV_TRAP: o = OFS_TRAP_BASE + {26'h0, tn, 2'h0}; // RULE_10
      EV_EXT_IRQ: o = OFS_EXT_IRQ; // RULE_11
      EV_COPRO_IRQ: o = OFS_COPRO_IRQ; // RULE_12
      EV_PRIV_OP: o = OFS_PRIV_OP; // RULE_13
      EV_FETCH_ACC,
      EV_LOAD_ACC: o = OFS_ACCESS; // RULE_14
      EV_FETCH_TLB,
      EV_LOAD_TLB: o = OFS_TLB; // RULE_15
      EV_COPRO_OFF: o = OFS_COPRO_OFF; // RULE_16
      default: o = OFS_POWER_ON;
    endcase
    return o;
  endfunction

  // interrupts clear stack select, exceptions and traps keep it
  function automatic logic is_irq_kind(evsel_ev_t c);
    return (c == EV_POWER_ON) || (c == EV_SYS_BREAK) ||
      (c == EV_EXT_IRQ) || (c == EV_COPRO_IRQ);
  endfunction

  // effective base: writable field plus the mmu flag on top
  function automatic logic [31:0] eff_base(logic [31:0] b, logic m);
    logic [31:0] e;
    e = b & VBASE_MASK;
    e[MMU_BIT] = m;
    return e;
  endfunction

  logic addr_ok;
  logic [31:0] ev_set;
  logic [INT_W-1:0] hw_set;

  // ******************************
  // next-state logic
  // ******************************
  // address phase is taken only with hready high and a real transfer
  assign addr_ok = HSEL && HTRANS[1] && HREADY;

  always_comb
  begin
    next_st = st;
    ev_set = 32'h0;
    hw_set = '0;
    next_st.vld = 1'b0;
    next_st.spc_vld = 1'b0;
    // flag follows the current translation mode each cycle
    next_st.mmu = XLATE_ON; // RULE_05

    // vector and status for each accepted event, saved pc for all but power-on
    if (EV_VALID)
    begin
      next_st.vld = 1'b1;
      hw_set[INT_VECTOR] = 1'b1;
      if (EV_CODE == EV_POWER_ON)
      begin
        next_st.vaddr = OFS_POWER_ON; // RULE_01
        next_st.acc_area = 1'b0;
      end
      else
      begin
        // base field sits at zero until written, so after reset the
        // offsets are absolute except for the mmu flag on bit 31
        ev_set = eff_base(st.base, st.mmu) + ofs_of(EV_CODE, EV_TRAP_NUM); // RULE_09
        next_st.vaddr = ev_set; // RULE_04
        // user mode with translation on lands in the access area
        next_st.acc_area = st.mmu && USER_MODE_IN; // RULE_04
        hw_set[INT_ACC_AREA] = st.mmu && USER_MODE_IN;
      end
      // stack select cleared only for the interrupt kinds
      next_st.ss = is_irq_kind(EV_CODE) ? 1'b0 : STACK_SEL_IN; // RULE_06
      next_st.um = 1'b0; // RULE_08
      next_st.ia = 1'b0; // RULE_13
      case (EV_CODE)
        // power-on leaves the saved pc undefined; keep it and no strobe
        EV_POWER_ON: next_st.spc_vld = 1'b0; // RULE_06
        EV_SYS_BREAK,
        EV_EXT_IRQ,
        EV_COPRO_IRQ:
        begin
          next_st.spc = EV_NEXT_PC; // RULE_11
          next_st.spc_vld = 1'b1;
        end
        EV_TRAP:
        begin
          next_st.spc = EV_PC + TRAP_PC_STEP; // RULE_10
          next_st.spc_vld = 1'b1;
        end
        default:
        begin
          next_st.spc = EV_PC; // RULE_14
          next_st.spc_vld = 1'b1;
        end
      endcase
    end
    else
    begin
      // hold the last mode bits as a stable view for fetch
      next_st.ss = st.ss;
      next_st.um = st.um;
      next_st.ia = st.ia;
    end

    // data phase of a bus write
    if (st.dph_wr)
    begin
      if (st.dph_addr == REG_VBASE)
      begin
        if (!st.locked)
        begin
          next_st.base = HWDATA & VBASE_MASK; // RULE_03
          next_st.locked = 1'b1; // RULE_17
        end
        else
        begin
          // late write dropped; flagged so software can see it
          hw_set[INT_LATE_WR] = 1'b1; // RULE_17
        end
      end
      else if (st.dph_addr == REG_INT_STAT)
      begin
        next_st.ist = st.ist & ~HWDATA[INT_W-1:0];
      end
      else if (st.dph_addr == REG_INT_MASK)
      begin
        next_st.imask = HWDATA[INT_W-1:0];
      end
    end

    // set beats clear so no event is lost
    next_st.ist = next_st.ist | hw_set;

    // address phase: latch for the write data phase
    next_st.dph_wr = addr_ok && HWRITE;
    next_st.dph_addr = {3'h0, HADDR[4:0]};

    // reads come from the next state, so a write just before is seen
    next_st.rdata = 32'h0;
    if (addr_ok && !HWRITE)
    begin
      if (HADDR[4:0] == REG_VBASE[4:0])
      begin
        next_st.rdata = eff_base(next_st.base, next_st.mmu);
      end
      else if (HADDR[4:0] == REG_STATE[4:0])
      begin
        // accept bit rides on top so every psw input stays visible
        next_st.rdata = {27'h0, IRQ_ACCEPT_IN, USER_MODE_IN, STACK_SEL_IN,
          next_st.mmu, next_st.locked};
      end
      else if (HADDR[4:0] == REG_INT_STAT[4:0])
      begin
        next_st.rdata = {{(32-INT_W){1'b0}}, next_st.ist};
      end
      else if (HADDR[4:0] == REG_INT_MASK[4:0])
      begin
        next_st.rdata = {{(32-INT_W){1'b0}}, next_st.imask};
      end
      else if (HADDR[4:0] == REG_LAST_PC[4:0])
      begin
        next_st.rdata = next_st.spc;
      end
      else
      begin
        // unmapped reads answer zero
        next_st.rdata = 32'h0;
      end
    end

    // interrupt line registered from the next-state status and mask
    next_st.irq = |(next_st.ist & next_st.imask);
  end

  // ******************************
  // state register
  // ******************************
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st <= '0;
      st.base <= VBASE_RESET; // RULE_02
    end
    else
    begin
      st <= next_st;
    end
  end

  // ******************************
  // outputs
  // ******************************
  // zero wait states; response never signals an error
  logic hready_q;
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      // ready already during reset, so the bus never sees a stall
      hready_q <= 1'b1;
    end
    else
    begin
      hready_q <= 1'b1;
    end
  end

  assign HREADYOUT = hready_q;
  assign HRESP = 1'b0;
  assign HRDATA = st.rdata;
  assign VEC_VALID = st.vld;
  assign VEC_ADDR = st.vaddr;
  assign VEC_ACC_AREA = st.acc_area;
  assign STACK_SEL_OUT = st.ss;
  assign USER_MODE_OUT = st.um;
  assign IRQ_ACCEPT_OUT = st.ia;
  assign SAVED_PC = st.spc;
  assign SAVED_PC_VALID = st.spc_vld;
  assign IRQ = st.irq;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  chk_power_on_zero: assert property ( // RULE_01
    EV_VALID && EV_CODE == EV_POWER_ON |=> VEC_VALID && VEC_ADDR == 32'h0)
    else $error("power-on entry not at zero");

  chk_base_reset: assert property ( // RULE_02
    !st.locked |-> (st.base == 32'h0))
    else $error("base moved before first write");

  chk_write_once: assert property ( // RULE_03
    st.locked |=> st.locked && $stable(st.base))
    else $error("base changed after lock");

  chk_late_write_flag: assert property ( // RULE_17
    st.dph_wr && st.dph_addr == REG_VBASE && st.locked
      |=> st.ist[INT_LATE_WR] && $stable(st.base))
    else $error("late base write not ignored");

  chk_range_field: assert property ( // RULE_04
    EV_VALID && EV_CODE != EV_POWER_ON
      |=> VEC_ADDR[30:29] == 2'h0 && VEC_ACC_AREA == $past(st.mmu && USER_MODE_IN))
    else $error("vector outside entry range");

  chk_msb_flag: assert property ( // RULE_05
    EV_VALID && EV_CODE != EV_POWER_ON |=> VEC_ADDR[31] == $past(st.mmu))
    else $error("top bit does not follow flag");

  chk_offset_sum: assert property ( // RULE_09
    EV_VALID && EV_CODE != EV_POWER_ON
      |=> VEC_ADDR == $past(eff_base(st.base, st.mmu)) +
        ofs_of($past(EV_CODE), $past(EV_TRAP_NUM)))
    else $error("wrong vector offset");

  chk_irq_clears: assert property ( // RULE_11
    EV_VALID && is_irq_kind(EV_CODE)
      |=> !STACK_SEL_OUT && !USER_MODE_OUT && !IRQ_ACCEPT_OUT)
    else $error("interrupt did not clear mode bits");

  chk_fault_keeps: assert property ( // RULE_08
    EV_VALID && !is_irq_kind(EV_CODE)
      |=> STACK_SEL_OUT == $past(STACK_SEL_IN) && !USER_MODE_OUT)
    else $error("fault changed stack select");

  chk_trap_pc: assert property ( // RULE_10
    EV_VALID && EV_CODE == EV_TRAP
      |=> SAVED_PC_VALID && SAVED_PC == $past(EV_PC) + 32'h4)
    else $error("trap saved pc wrong");

  chk_next_pc: assert property ( // RULE_07
    EV_VALID && EV_CODE == EV_SYS_BREAK |=> SAVED_PC == $past(EV_NEXT_PC))
    else $error("break saved pc wrong");

  cov_trap: cover property (EV_VALID && EV_CODE == EV_TRAP ##1 VEC_VALID);
  cov_lock: cover property (!st.locked ##1 st.locked);
  cov_irq: cover property (IRQ ##1 !IRQ);
endmodule

// ===== tb/evsel_partner.sv
// far-side model: event detection and priority stage feeding the selector
// assumes the caller invokes send and quiet right after a rising edge
`timescale 1ns/100ps
module evsel_partner (
  input wire logic clk,
  output logic ev_valid,
  output evsel_pkg::evsel_ev_t ev_code,
  output logic [3:0] ev_trap_num,
  output logic [31:0] ev_pc,
  output logic [31:0] ev_next_pc
);
  import evsel_pkg::*;
  // quiet start so the selector sees no event before reset ends
  initial
  begin
    ev_valid = 1'b0;
    ev_code = EV_POWER_ON;
    ev_trap_num = 4'h0;
    ev_pc = 32'h0;
    ev_next_pc = 32'h0;
  end
  // one accepted event per cycle, back to back when called in a row
  task automatic send(input evsel_ev_t c, input logic [3:0] n,
                      input logic [31:0] p, input logic [31:0] np);
    @(posedge clk);
    ev_valid <= 1'b1;
    ev_code <= c;
    ev_trap_num <= n;
    ev_pc <= p;
    ev_next_pc <= np;
  endtask
  // released trap number and pcs are scrambled so stale values never pass for fresh
  task automatic quiet();
    @(posedge clk);
    ev_valid <= 1'b0;
    ev_trap_num <= ~ev_trap_num;
    ev_pc <= ~ev_pc;
    ev_next_pc <= ~ev_next_pc;
  endtask
endmodule

// ===== tb/exception_vector_select_bench.sv
// self-checking bench for the exception vector selector
// assumes one 100 MHz clock, zero-wait bus slave, one-cycle event answer
`timescale 1ns/100ps
module exception_vector_select_bench;
  import evsel_pkg::*;
  typedef struct {
    logic [31:0] addr;
    logic [31:0] spc;
    logic spcv;
    logic ss;
    logic acc;
  } evsel_exp_t;
  logic REF_CLK = 1'b0, NRST = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, XLATE_ON = 1'b0;
  logic [11:0] HADDR = 12'h0;
  logic [1:0] HTRANS = 2'b00;
  logic [2:0] HSIZE = 3'b010;
  logic [31:0] HWDATA = 32'h0, HRDATA, VEC_ADDR, SAVED_PC, EV_PC, EV_NEXT_PC;
  logic HREADYOUT, HRESP, EV_VALID, VEC_VALID, VEC_ACC_AREA, SAVED_PC_VALID, IRQ;
  logic STACK_SEL_IN = 1'b0, USER_MODE_IN = 1'b0, IRQ_ACCEPT_IN = 1'b0;
  logic STACK_SEL_OUT, USER_MODE_OUT, IRQ_ACCEPT_OUT;
  logic [3:0] EV_TRAP_NUM;
  evsel_ev_t EV_CODE;
  logic [31:0] seed = 32'h4505df9f, base = 32'h0, last_spc = 32'h0;
  int err_count = 0, compares = 0;
  evsel_exp_t notes[$];
  always #5 REF_CLK = ~REF_CLK;
  evsel_partner u_part (.clk(REF_CLK), .ev_valid(EV_VALID), .ev_code(EV_CODE),
    .ev_trap_num(EV_TRAP_NUM), .ev_pc(EV_PC), .ev_next_pc(EV_NEXT_PC));
  evsel dut (.REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EV_VALID(EV_VALID), .EV_CODE(EV_CODE),
    .EV_TRAP_NUM(EV_TRAP_NUM), .EV_PC(EV_PC), .EV_NEXT_PC(EV_NEXT_PC), .XLATE_ON(XLATE_ON),
    .STACK_SEL_IN(STACK_SEL_IN), .USER_MODE_IN(USER_MODE_IN), .IRQ_ACCEPT_IN(IRQ_ACCEPT_IN),
    .VEC_VALID(VEC_VALID), .VEC_ADDR(VEC_ADDR), .VEC_ACC_AREA(VEC_ACC_AREA),
    .STACK_SEL_OUT(STACK_SEL_OUT), .USER_MODE_OUT(USER_MODE_OUT),
    .IRQ_ACCEPT_OUT(IRQ_ACCEPT_OUT), .SAVED_PC(SAVED_PC), .SAVED_PC_VALID(SAVED_PC_VALID),
    .IRQ(IRQ));
  // ******************************
  // helpers
  // ******************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic end_of_test();
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // single word transfer; address held until hready, data phase after
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {4'h0, a};
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= w ? d : ~HWDATA;
    do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check("hrdata", r, exp);
  endtask
  // drive one event with random pcs and psw, note what must come back
  task automatic ev(input evsel_ev_t c, input logic [3:0] n);
    evsel_exp_t e;
    logic [31:0] p, np, ofs;
    seed = xs(seed);
    p = seed;
    seed = xs(seed);
    np = seed;
    case (c)
      EV_SYS_BREAK: ofs = 32'h10;
      EV_UNK_OPCODE: ofs = 32'h20;
      EV_MISALIGN: ofs = 32'h30;
      EV_TRAP: ofs = 32'h40 + {26'h0, n, 2'b00};
      EV_EXT_IRQ: ofs = 32'h80;
      EV_COPRO_IRQ: ofs = 32'h90;
      EV_PRIV_OP: ofs = 32'h100;
      EV_FETCH_ACC, EV_LOAD_ACC: ofs = 32'h110;
      EV_FETCH_TLB, EV_LOAD_TLB: ofs = 32'h120;
      default: ofs = 32'h160;
    endcase
    e.addr = (c == EV_POWER_ON) ? 32'h0 : {XLATE_ON, 2'b00, base[28:16], 16'h0} + ofs;
    e.ss = (c inside {EV_POWER_ON, EV_SYS_BREAK, EV_EXT_IRQ, EV_COPRO_IRQ}) ? 1'b0 : seed[7];
    e.spc = (c inside {EV_SYS_BREAK, EV_EXT_IRQ, EV_COPRO_IRQ}) ? np : p;
    if (c == EV_TRAP)
      e.spc = p + 32'h4;
    e.spcv = (c != EV_POWER_ON);
    // power-on entry sits at zero, never in the access area
    e.acc = (c != EV_POWER_ON) & XLATE_ON & seed[8];
    if (e.spcv)
      last_spc = e.spc;
    notes.push_back(e);
    u_part.send(c, n, p, np);
    STACK_SEL_IN <= seed[7];
    USER_MODE_IN <= seed[8];
    IRQ_ACCEPT_IN <= seed[9];
  endtask
  // every code once, then all sixteen traps back to back
  task automatic run_all();
    for (int i = 0; i < 13; i++)
      ev(evsel_ev_t'(i), 4'h0);
    for (int n = 0; n < 16; n++)
      ev(EV_TRAP, n[3:0]);
    u_part.quiet();
    repeat (3) @(posedge REF_CLK);
  endtask
  // ******************************
  // output watcher: oldest note against each vector issued
  // ******************************
  always @(negedge REF_CLK)
  begin
    if (VEC_VALID === 1'b1)
    begin
      evsel_exp_t e;
      if (notes.size() == 0)
        check("unexpected vector", 32'h1, 32'h0);
      else
      begin
        e = notes.pop_front();
        check("vec_addr", VEC_ADDR, e.addr);
        check("stack_sel", {31'h0, STACK_SEL_OUT}, {31'h0, e.ss});
        check("user_irq", {30'h0, USER_MODE_OUT, IRQ_ACCEPT_OUT}, 32'h0);
        check("pc_valid", {31'h0, SAVED_PC_VALID}, {31'h0, e.spcv});
        if (e.spcv)
          check("saved_pc", SAVED_PC, e.spc);
        check("acc_area", {31'h0, VEC_ACC_AREA}, {31'h0, e.acc});
      end
    end
  end
  initial
  begin
    repeat (20000) @(posedge REF_CLK);
    err_count++;
    end_of_test();
  end
  // ******************************
  // main sequence
  // ******************************
  initial
  begin
    repeat (16) @(posedge REF_CLK);
    NRST <= 1'b1;
    rd(8'h00, 32'h0);
    run_all();
    wr(8'h00, 32'hf234_5678);
    base = 32'h1234_0000;
    rd(8'h00, base);
    wr(8'h00, 32'h0abc_0000);
    rd(8'h00, base);
    rd(8'h08, 32'h3);
    run_all();
    XLATE_ON <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    rd(8'h00, base | 32'h8000_0000);
    rd(8'h04, {27'h0, IRQ_ACCEPT_IN, USER_MODE_IN, STACK_SEL_IN, 2'b11});
    rd(8'h10, last_spc);
    run_all();
    wr(8'h0c, 32'h1);
    repeat (2) @(negedge REF_CLK);
    check("irq", {31'h0, IRQ}, 32'h1);
    wr(8'h08, 32'h7);
    repeat (2) @(negedge REF_CLK);
    check("irq", {31'h0, IRQ}, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h1c, 32'h0);
    @(posedge REF_CLK);
    NRST <= 1'b0;
    @(posedge REF_CLK);
    NRST <= 1'b1;
    base = 32'h0;
    repeat (2) @(posedge REF_CLK);
    rd(8'h00, 32'h8000_0000);
    wr(8'h00, 32'h0005_0000);
    base = 32'h0005_0000;
    run_all();
    check("notes left", notes.size(), 32'h0);
    end_of_test();
  end
endmodule
